// ===== rtcirq_alarm.sv
// Alarm comparator: checks the applied alarm fields once per seconds update.
// Assumes the time fields and sec_tick come from counters in the pclk domain.
`timescale 1ns/1ps
`include "rtcirq_consts.svh"
module rtcirq_alarm (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst_n,
    // Current time.
    input wire logic sec_tick,
    input wire logic [6:0] cur_sec,
    input wire logic [6:0] cur_min,
    input wire logic [5:0] cur_hour,
    input wire logic [5:0] cur_date,
    // Applied alarm fields, match bit in bit 7.
    input wire logic [7:0] alm_sec,
    input wire logic [7:0] alm_min,
    input wire logic [7:0] alm_hour,
    input wire logic [7:0] alm_date,
    // Match event.
    output logic match
);
    logic all_off;
    logic hit;

    // A field passes when excluded by its match bit or equal to the time.
    function automatic logic field_ok(input logic [7:0] alm, input logic [6:0] cur);
        field_ok = alm[`RTCIRQ_ALM_M] || (alm[6:0] == cur);
    endfunction : field_ok

    // Every match bit set disables the alarm completely.
    assign all_off = alm_sec[`RTCIRQ_ALM_M] && alm_min[`RTCIRQ_ALM_M]
        && alm_hour[`RTCIRQ_ALM_M] && alm_date[`RTCIRQ_ALM_M];
    assign hit = !all_off && field_ok(alm_sec, cur_sec) && field_ok(alm_min, cur_min)
        && field_ok(alm_hour, {1'b0, cur_hour}) && field_ok(alm_date, {1'b0, cur_date});

    // One match pulse per seconds update.
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            match <= 1'b0;
        else
            match <= sec_tick && hit;
    end

    property p_alarm_disabled;
        @(posedge clk) disable iff (!rst_n) all_off |=> !match;
    endproperty
    a_alarm_disabled: assert property (p_alarm_disabled)
        else $error("Alarm fired with every match bit set.");

endmodule : rtcirq_alarm

// ===== rtcirq_consts.svh
// Register indices, field positions, reset values and timing for the RTC interrupt block.
// Assumes a 32-bit APB where each register index occupies one word (byte address = index * 4).
`ifndef RTCIRQ_CONSTS_SVH
`define RTCIRQ_CONSTS_SVH

// Register indices, compared against paddr[21:2].
`define RTCIRQ_IDX_FLAGS 20'hFFFF0
`define RTCIRQ_IDX_ALM_SEC 20'hFFFF2
`define RTCIRQ_IDX_ALM_MIN 20'hFFFF3
`define RTCIRQ_IDX_ALM_HOUR 20'hFFFF4
`define RTCIRQ_IDX_ALM_DATE 20'hFFFF5
`define RTCIRQ_IDX_INT 20'hFFFF6
`define RTCIRQ_IDX_WDOG 20'hFFFF7

// Event flags field positions.
`define RTCIRQ_FLG_WDF 7
`define RTCIRQ_FLG_AF 6
`define RTCIRQ_FLG_PF 5
`define RTCIRQ_FLG_OSC_FAIL_FLAG 4
`define RTCIRQ_FLG_CAL 2
`define RTCIRQ_FLG_W 1
`define RTCIRQ_FLG_R 0

// Interrupt control field positions.
`define RTCIRQ_INT_WIE 7
`define RTCIRQ_INT_AIE 6
`define RTCIRQ_INT_PFE 5
`define RTCIRQ_INT_HL 3
`define RTCIRQ_INT_PL 2

// Watchdog control field positions and alarm match bit.
`define RTCIRQ_WD_STROBE 7
`define RTCIRQ_WD_LOCK 6
`define RTCIRQ_ALM_M 7

// Reset values.
`define RTCIRQ_FLAGS_RST 8'h00
`define RTCIRQ_INT_RST 8'h08
`define RTCIRQ_WDT_RST 6'h00
`define RTCIRQ_ALM_RST 8'h80

// Timing: interrupt pulse length in ms and clock rate in MHz.
`define RTCIRQ_PULSE_MS 200
`define RTCIRQ_CLK_MHZ 200

`endif

// ===== rtcirq_host.sv
// Host-side model of the interrupt pin with its external pull-up.
// Assumes the block drives int_o only while int_oe_n is low.
`timescale 1ns/1ps
module rtcirq_host (
    // Pin drive from the block and polarity in use.
    input wire logic int_o,
    input wire logic int_oe_n,
    input wire logic hl,
    // Resolved pin and decoded request.
    output logic int_pin,
    output logic int_act
);
    // The pull-up holds the pin high while nobody drives it.
    assign int_pin = int_oe_n ? 1'b1 : int_o;
    // The host decodes the active level from the polarity.
    assign int_act = hl ? int_pin : ~int_pin;
endmodule : rtcirq_host

// ===== rtcirq_pkg.sv
// Types shared by the RTC interrupt block.
// Assumes nothing beyond a SystemVerilog compiler.
package rtcirq_pkg;

    // States of the interrupt pulse generator.
    typedef enum logic {
        st_idle,
        st_pulse
    } rtcirq_pulse_state_t;

endpackage : rtcirq_pkg

// ===== rtcirq_top.sv
// RTC alarm, watchdog and interrupt logic with an APB register slave.
// Assumes time fields and sec_tick on pclk; oscillator and power signals are asynchronous pins.
// What this block does
// - Alarm match against current time sets alarm flag, interrupts when enabled.
// - Each alarm field has a match bit; zero includes the field.
// - All match bits one disables alarm; all zero needs exact match.
// - Reading the flags register clears alarm flag and the watchdog and power-fail flags.
// - Host sets write-hold around alarm writes; values apply when it clears.
// - Watchdog counts down on the 32 Hz tick only with oscillator running.
// - At power-up the stored timeout loads and counting starts at once.
// - Writing the strobe reloads the timeout and restarts the countdown.
// - Reaching zero sets the watchdog flag and interrupts when enabled.
// - Timeout bits are written only while the write-lock bit is zero.
// - A timeout value of zero disables the watchdog entirely.
// - On backup supply host access is blocked; counting continues inside.
// - Interrupt asserts only for a set flag with its enable at one.
// - Pulse mode drives the interrupt active for about 200 ms.
// - No interrupts are raised while running from the backup supply.
// - With enable zero an event only sets its own flag.
// - Polarity one: active high push-pull; zero: active low open-drain.
// - Pulse/level zero holds the pin active until flags are read.
// - Reading flags during a pulse clears flags and ends the pulse.
// - Power-up clears the whole flags register, the oscillator-failed bit included.
// - Write-hold bit freezes timekeeping updates and allows them to be set.
`timescale 1ns/1ps
`include "rtcirq_consts.svh"
module rtcirq_top #(
    parameter int unsigned PULSE_CYCLES = `RTCIRQ_PULSE_MS * 1000 * `RTCIRQ_CLK_MHZ,
    parameter int PCW = 26,
    parameter logic [5:0] WDT_INIT = `RTCIRQ_WDT_RST
) (
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // APB slave.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [21:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Time from the timekeeping counters.
    input wire logic sec_tick,
    input wire logic [6:0] cur_sec,
    input wire logic [6:0] cur_min,
    input wire logic [5:0] cur_hour,
    input wire logic [5:0] cur_date,
    // Asynchronous oscillator and power pins.
    input wire logic osc_tick_32hz,
    input wire logic osc_running,
    input wire logic vcc_above_switch,
    input wire logic pwr_fail_det,
    input wire logic osc_fail_det,
    // Controls to the timekeeping logic.
    output logic time_write_hold,
    output logic time_read_hold,
    output logic cal_out_en,
    // Interrupt pin.
    output logic int_o,
    output logic int_oe_n
);
    localparam int NS = 5;
    logic [NS-1:0] sync1_q;
    logic [NS-1:0] sync2_q;
    logic [NS-1:0] sync3_q;
    logic tick_rise;
    logic osc_run;
    logic on_primary;
    logic pf_rise;
    logic osc_fail_flag_rise;
    logic setup;
    logic acc;
    logic acc_wr;
    logic rd_flags;
    logic mapped;
    logic wdf_q;
    logic af_q;
    logic pf_q;
    logic osc_fail_flag_q;
    logic cal_q;
    logic w_q;
    logic r_q;
    logic wdf_d;
    logic af_d;
    logic pf_d;
    logic [7:0] int_ctl_q;
    logic wdw_q;
    logic [5:0] wdt_q;
    logic wd_reload_q;
    logic wd_expire;
    logic [7:0] alm_stage_q [4];
    logic [7:0] alm_act_q [4];
    logic w_fall;
    logic alarm_match;
    logic irq_src_d;
    logic irq_new;
    rtcirq_pkg::rtcirq_pulse_state_t pst_q;
    rtcirq_pkg::rtcirq_pulse_state_t pst_d;
    logic [PCW-1:0] pcnt_q;
    logic int_active_q;
    logic [7:0] rd_byte;

    // Address decode against a register index.
    function automatic logic hit(input logic [21:0] a, input logic [19:0] idx);
        hit = (a[21:2] == idx);
    endfunction : hit

    // Two-stage synchronisers for the pins, plus a third stage for edge detection.
    genvar gi;
    generate
        for (gi = 0; gi < NS; gi++)
        begin : g_sync
            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                begin
                    sync1_q[gi] <= 1'b0;
                    sync2_q[gi] <= 1'b0;
                    sync3_q[gi] <= 1'b0;
                end
                else
                begin
                    sync1_q[gi] <= (gi == 0) ? osc_tick_32hz : (gi == 1) ? osc_running :
                        (gi == 2) ? vcc_above_switch : (gi == 3) ? pwr_fail_det : osc_fail_det;
                    sync2_q[gi] <= sync1_q[gi];
                    sync3_q[gi] <= sync2_q[gi];
                end
            end
        end
    endgenerate

    // Synchronised levels and edges.
    assign tick_rise = sync2_q[0] && !sync3_q[0];
    assign osc_run = sync2_q[1];
    assign on_primary = sync2_q[2];
    assign pf_rise = sync2_q[3] && !sync3_q[3];
    assign osc_fail_flag_rise = sync2_q[4] && !sync3_q[4];

    // APB phases; access is refused while on backup supply.
    assign setup = psel && !penable;
    assign acc = psel && penable && on_primary;
    assign acc_wr = acc && pwrite;
    assign rd_flags = acc && !pwrite && hit(paddr, `RTCIRQ_IDX_FLAGS);
    assign mapped = hit(paddr, `RTCIRQ_IDX_FLAGS) || hit(paddr, `RTCIRQ_IDX_INT)
        || hit(paddr, `RTCIRQ_IDX_WDOG) || (paddr[21:2] >= `RTCIRQ_IDX_ALM_SEC
        && paddr[21:2] <= `RTCIRQ_IDX_ALM_DATE);
    assign pready = 1'b1;
    assign pslverr = psel && penable && (!on_primary || !mapped);

    // Read data is captured in the setup phase so it holds the pre-clear flags.
    always_comb
    begin
        rd_byte = 8'h00;
        if (hit(paddr, `RTCIRQ_IDX_FLAGS))
            rd_byte = {wdf_q, af_q, pf_q, osc_fail_flag_q, 1'b0, cal_q, w_q, r_q};
        else if (hit(paddr, `RTCIRQ_IDX_INT))
            rd_byte = int_ctl_q;
        else if (hit(paddr, `RTCIRQ_IDX_WDOG))
            rd_byte = {1'b0, wdw_q, wdt_q};
        else if (mapped)
            rd_byte = alm_stage_q[paddr[3:2] - 2'h2];
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata <= 32'h0000_0000;
        else if (setup)
            prdata <= on_primary ? {24'h00_0000, rd_byte} : 32'h0000_0000;
    end

    // Event flags: hardware set wins over the clear caused by a read.
    always_comb
    begin
        wdf_d = wd_expire || (wdf_q && !rd_flags);
        af_d = alarm_match || (af_q && !rd_flags);
        pf_d = pf_rise || (pf_q && !rd_flags);
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            wdf_q <= 1'b0;
            af_q <= 1'b0;
            pf_q <= 1'b0;
        end
        else
        begin
            wdf_q <= wdf_d;
            af_q <= af_d;
            pf_q <= pf_d;
        end
    end

    // Control bits of the flags register and the oscillator-failed flag.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            w_q <= 1'b0;
            r_q <= 1'b0;
            cal_q <= 1'b0;
            osc_fail_flag_q <= 1'b0;
        end
        else
        begin
            if (acc_wr && hit(paddr, `RTCIRQ_IDX_FLAGS))
            begin
                w_q <= pwdata[`RTCIRQ_FLG_W];
                r_q <= pwdata[`RTCIRQ_FLG_R];
                if (w_q)
                    cal_q <= pwdata[`RTCIRQ_FLG_CAL];
            end
            if (osc_fail_flag_rise)
                osc_fail_flag_q <= 1'b1;
            else if (acc_wr && hit(paddr, `RTCIRQ_IDX_FLAGS) && w_q && !pwdata[`RTCIRQ_FLG_OSC_FAIL_FLAG])
                osc_fail_flag_q <= 1'b0;
        end
    end

    assign time_write_hold = w_q;
    assign time_read_hold = r_q;
    assign cal_out_en = cal_q;

    // Interrupt control register.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            int_ctl_q <= `RTCIRQ_INT_RST;
        else if (acc_wr && hit(paddr, `RTCIRQ_IDX_INT))
            int_ctl_q <= pwdata[7:0] & 8'hEC;
    end

    // Watchdog control: timeout bits written only with the lock bit clear.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            wdw_q <= 1'b0;
            wdt_q <= WDT_INIT;
        end
        else if (acc_wr && hit(paddr, `RTCIRQ_IDX_WDOG))
        begin
            wdw_q <= pwdata[`RTCIRQ_WD_LOCK];
            if (!pwdata[`RTCIRQ_WD_LOCK])
                wdt_q <= pwdata[5:0];
        end
    end

    // The strobe is delayed one cycle so a timeout written in the same transfer is loaded.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            wd_reload_q <= 1'b0;
        else
            wd_reload_q <= acc_wr && hit(paddr, `RTCIRQ_IDX_WDOG)
                && pwdata[`RTCIRQ_WD_STROBE];
    end

    rtcirq_wdog #(
        .TW(6)
    ) u_wdog (
        .clk(pclk),
        .rst_n(presetn),
        .tick(tick_rise),
        .osc_run(osc_run),
        .timeout(wdt_q),
        .reload(wd_reload_q),
        .expire(wd_expire)
    );

    // Alarm staging takes writes under write-hold; the applied copy loads when it clears.
    assign w_fall = w_q && acc_wr && hit(paddr, `RTCIRQ_IDX_FLAGS) && !pwdata[`RTCIRQ_FLG_W];

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            for (int i = 0; i < 4; i++)
            begin
                alm_stage_q[i] <= `RTCIRQ_ALM_RST;
                alm_act_q[i] <= `RTCIRQ_ALM_RST;
            end
        end
        else
        begin
            if (acc_wr && w_q && paddr[21:2] >= `RTCIRQ_IDX_ALM_SEC
                && paddr[21:2] <= `RTCIRQ_IDX_ALM_DATE)
                alm_stage_q[paddr[3:2] - 2'h2] <= pwdata[7:0];
            if (w_fall)
                alm_act_q <= alm_stage_q;
        end
    end

    rtcirq_alarm u_alarm (
        .clk(pclk),
        .rst_n(presetn),
        .sec_tick(sec_tick),
        .cur_sec(cur_sec),
        .cur_min(cur_min),
        .cur_hour(cur_hour),
        .cur_date(cur_date),
        .alm_sec(alm_act_q[0]),
        .alm_min(alm_act_q[1]),
        .alm_hour(alm_act_q[2]),
        .alm_date(alm_act_q[3]),
        .match(alarm_match)
    );

    // Enabled sources, gated off on backup supply.
    assign irq_src_d = on_primary && ((wdf_d && int_ctl_q[`RTCIRQ_INT_WIE])
        || (af_d && int_ctl_q[`RTCIRQ_INT_AIE]) || (pf_d && int_ctl_q[`RTCIRQ_INT_PFE]));
    assign irq_new = on_primary && ((wd_expire && int_ctl_q[`RTCIRQ_INT_WIE])
        || (alarm_match && int_ctl_q[`RTCIRQ_INT_AIE]) || (pf_rise && int_ctl_q[`RTCIRQ_INT_PFE]));

    // Pulse generator: starts on a new enabled event, ends on timeout or a flags read.
    always_comb
    begin
        pst_d = pst_q;
        unique case (pst_q)
            rtcirq_pkg::st_idle:
                if (irq_new && int_ctl_q[`RTCIRQ_INT_PL])
                    pst_d = rtcirq_pkg::st_pulse;
            rtcirq_pkg::st_pulse:
                if (rd_flags || !on_primary || pcnt_q == PCW'(PULSE_CYCLES - 1))
                    pst_d = rtcirq_pkg::st_idle;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pst_q <= rtcirq_pkg::st_idle;
            pcnt_q <= '0;
        end
        else
        begin
            pst_q <= pst_d;
            pcnt_q <= (pst_q == rtcirq_pkg::st_pulse) ? pcnt_q + PCW'(1) : '0;
        end
    end

    // Active state of the pin: pulse in pulse mode, held source in level mode.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            int_active_q <= 1'b0;
        else if (int_ctl_q[`RTCIRQ_INT_PL])
            int_active_q <= (pst_d == rtcirq_pkg::st_pulse) && on_primary;
        else
            int_active_q <= irq_src_d;
    end

    // Pin driver: push-pull active high, or open-drain active low.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            int_o <= 1'b0;
            int_oe_n <= 1'b1;
        end
        else if (int_ctl_q[`RTCIRQ_INT_HL])
        begin
            int_o <= int_active_q;
            int_oe_n <= !on_primary;
        end
        else
        begin
            int_o <= 1'b0;
            int_oe_n <= !(int_active_q && on_primary);
        end
    end

    property p_af_set;
        @(posedge pclk) disable iff (!presetn) alarm_match |=> af_q;
    endproperty
    a_af_set: assert property (p_af_set)
        else $error("Alarm match did not set the alarm flag.");

    property p_rd_clears;
        @(posedge pclk) disable iff (!presetn)
            rd_flags && !alarm_match && !wd_expire && !pf_rise |=> !af_q && !wdf_q && !pf_q;
    endproperty
    a_rd_clears: assert property (p_rd_clears)
        else $error("Flags read did not clear the event flags.");

    property p_alarm_hold;
        @(posedge pclk) disable iff (!presetn) w_q && !w_fall |=> $stable(alm_act_q[0]);
    endproperty
    a_alarm_hold: assert property (p_alarm_hold)
        else $error("Applied alarm changed while write-hold was set.");

    property p_wdt_lock;
        @(posedge pclk) disable iff (!presetn)
            acc_wr && hit(paddr, `RTCIRQ_IDX_WDOG) && pwdata[`RTCIRQ_WD_LOCK] |=> $stable(wdt_q);
    endproperty
    a_wdt_lock: assert property (p_wdt_lock)
        else $error("Timeout bits changed under write lock.");

    property p_backup_quiet;
        @(posedge pclk) disable iff (!presetn) !on_primary ##1 !on_primary |=> int_oe_n;
    endproperty
    a_backup_quiet: assert property (p_backup_quiet)
        else $error("Interrupt pin driven on backup supply.");

    property p_level_needs_src;
        @(posedge pclk) disable iff (!presetn)
            !int_ctl_q[`RTCIRQ_INT_PL] && !irq_src_d |=> !int_active_q;
    endproperty
    a_level_needs_src: assert property (p_level_needs_src)
        else $error("Interrupt active without an enabled flag.");

    property p_level_holds;
        @(posedge pclk) disable iff (!presetn)
            !int_ctl_q[`RTCIRQ_INT_PL] && irq_src_d |=> int_active_q;
    endproperty
    a_level_holds: assert property (p_level_holds)
        else $error("Level interrupt dropped before the flags read.");

    property p_pulse_cut;
        @(posedge pclk) disable iff (!presetn)
            pst_q == rtcirq_pkg::st_pulse && rd_flags |=> pst_q == rtcirq_pkg::st_idle && !int_active_q;
    endproperty
    a_pulse_cut: assert property (p_pulse_cut)
        else $error("Flags read did not end the interrupt pulse.");

endmodule : rtcirq_top

// ===== rtcirq_wdog.sv
// Watchdog down-counter clocked by a synchronised 32 Hz tick.
// Assumes tick is a one-cycle pulse already in the pclk domain.
`timescale 1ns/1ps
module rtcirq_wdog #(
    parameter int TW = 6
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst_n,
    // Tick and controls.
    input wire logic tick,
    input wire logic osc_run,
    input wire logic [TW-1:0] timeout,
    input wire logic reload,
    // Timeout event.
    output logic expire
);
    logic [TW-1:0] cnt_q;
    logic armed_q;
    logic step;

    // A tick counts only with the oscillator running and a nonzero timeout.
    assign step = tick && osc_run && (timeout != '0);

    // Load after reset or strobe, then count down and restart on reaching zero.
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cnt_q <= '0;
            armed_q <= 1'b0;
        end
        else if (!armed_q || reload)
        begin
            cnt_q <= timeout;
            armed_q <= 1'b1;
        end
        else if (step)
        begin
            cnt_q <= (cnt_q <= TW'(1)) ? timeout : cnt_q - TW'(1);
        end
    end

    // Expiry is flagged when the count steps from one to zero.
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            expire <= 1'b0;
        else
            expire <= armed_q && !reload && step && (cnt_q <= TW'(1));
    end

    property p_wdog_zero_silent;
        @(posedge clk) disable iff (!rst_n) (timeout == '0) |=> !expire;
    endproperty
    a_wdog_zero_silent: assert property (p_wdog_zero_silent)
        else $error("Watchdog expired with zero timeout.");

    property p_wdog_needs_osc;
        @(posedge clk) disable iff (!rst_n) expire |-> $past(tick && osc_run && !reload);
    endproperty
    a_wdog_needs_osc: assert property (p_wdog_needs_osc)
        else $error("Watchdog expired without a running-oscillator tick.");

endmodule : rtcirq_wdog

// ===== tb_top.sv
// Self-checking bench for the RTC alarm, watchdog and interrupt block.
// Assumes the host model resolves the pin; pulse length is shortened.
`timescale 1ns/1ps
module tb_top;
    // Bench signals.
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [21:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd;
    logic pready, pslverr, er, stk = 0, otk = 0, orun = 1, vcc = 1, pfd = 0, hl = 1;
    logic [6:0] csec = '0, cmin = '0;
    logic int_o, int_oe_n, int_pin, int_act;
    int error_cnt = 0, n_tests = 0, n;
    logic [28:0] rows [8] = '{{20'hFFFF0, 8'h00, 1'b0}, {20'hFFFF2, 8'h80, 1'b0},
        {20'hFFFF3, 8'h80, 1'b0}, {20'hFFFF4, 8'h80, 1'b0}, {20'hFFFF5, 8'h80, 1'b0},
        {20'hFFFF6, 8'h08, 1'b0}, {20'hFFFF7, 8'h00, 1'b0}, {20'hFFFF1, 8'h00, 1'b1}};
    // Design with a short pulse, and the host model.
    rtcirq_top #(.PULSE_CYCLES(20)) u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .sec_tick(stk), .cur_sec(csec), .cur_min(cmin),
        .cur_hour(6'h00), .cur_date(6'h00), .osc_tick_32hz(otk), .osc_running(orun),
        .vcc_above_switch(vcc), .pwr_fail_det(pfd), .osc_fail_det(1'b0),
        .time_write_hold(), .time_read_hold(), .cal_out_en(), .int_o(int_o),
        .int_oe_n(int_oe_n));
    rtcirq_host u_host (.int_o(int_o), .int_oe_n(int_oe_n), .hl(hl), .int_pin(int_pin),
        .int_act(int_act));
    // Free-running 5 ns clock.
    initial
    begin
        forever #2.5 pclk = ~pclk;
    end
    // Prints the verdict and stops.
    task automatic end_of_test();
        if (error_cnt == 0 && n_tests > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : end_of_test
    // Compares one result and counts it.
    task automatic chk(input logic [31:0] g, input logic [31:0] x);
        n_tests++;
        if (g !== x)
        begin
            error_cnt++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, x);
        end
    endtask : chk
    // One APB transfer, held until pready is seen high.
    task automatic apb(input logic w, input logic [19:0] i, input logic [7:0] d);
        int k;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {i, 2'b00};
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        for (k = 0; k < 50; k++)
        begin
            @(posedge pclk);
            if (pready === 1'b1)
                break;
        end
        if (k == 50)
        begin
            error_cnt++;
            end_of_test();
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    // Waits a bounded time for the host to see the given request level.
    task automatic wint(input logic lv, input int mx);
        for (n = 0; n < mx; n++)
        begin
            @(posedge pclk);
            if (int_act === lv)
                break;
        end
        if (n == mx)
        begin
            error_cnt++;
            end_of_test();
        end
    endtask : wint
    // One 32 Hz period, and one seconds update at a given second.
    task automatic otick();
        @(posedge pclk);
        otk <= 1'b1;
        repeat (4) @(posedge pclk);
        otk <= 1'b0;
        repeat (5) @(posedge pclk);
    endtask : otick
    task automatic stick(input logic [6:0] s);
        @(posedge pclk);
        csec <= s;
        stk <= 1'b1;
        @(posedge pclk);
        stk <= 1'b0;
        repeat (4) @(posedge pclk);
    endtask : stick
    // Main sequence.
    initial
    begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        repeat (4) @(posedge pclk);
        foreach (rows[i])
        begin
            apb(1'b0, rows[i][28:9], 8'h00);
            chk({rd[30:0], er}, {23'h0, rows[i][8:1], rows[i][0]});
        end
        apb(1'b1, 20'hFFFF6, 8'h88);
        apb(1'b1, 20'hFFFF7, 8'h82);
        otick();
        chk(int_act, 1'b0);
        otick();
        wint(1'b1, 40);
        apb(1'b0, 20'hFFFF0, 8'h00);
        chk(rd, 32'h80);
        wint(1'b0, 5);
        apb(1'b1, 20'hFFFF7, 8'h82);
        otick();
        apb(1'b1, 20'hFFFF7, 8'hC5);
        otick();
        apb(1'b0, 20'hFFFF0, 8'h00);
        chk(rd, 32'h00);
        apb(1'b0, 20'hFFFF7, 8'h00);
        chk(rd & 32'h3F, 32'h02);
        apb(1'b1, 20'hFFFF7, 8'h80);
        repeat (3) otick();
        apb(1'b1, 20'hFFFF6, 8'h08);
        apb(1'b1, 20'hFFFF7, 8'h81);
        orun <= 1'b0;
        otick();
        apb(1'b0, 20'hFFFF0, 8'h00);
        chk(rd, 32'h00);
        orun <= 1'b1;
        otick();
        chk(int_act, 1'b0);
        apb(1'b0, 20'hFFFF0, 8'h00);
        chk(rd, 32'h80);
        hl <= 1'b0;
        apb(1'b1, 20'hFFFF6, 8'h40);
        apb(1'b1, 20'hFFFF0, 8'h02);
        apb(1'b1, 20'hFFFF2, 8'h05);
        stick(7'h05);
        apb(1'b0, 20'hFFFF0, 8'h00);
        chk(rd, 32'h02);
        apb(1'b1, 20'hFFFF0, 8'h00);
        stick(7'h06);
        apb(1'b0, 20'hFFFF0, 8'h00);
        chk(rd, 32'h00);
        stick(7'h05);
        wint(1'b1, 40);
        chk(int_pin, 1'b0);
        apb(1'b0, 20'hFFFF0, 8'h00);
        chk(rd, 32'h40);
        wint(1'b0, 5);
        hl <= 1'b1;
        apb(1'b1, 20'hFFFF6, 8'h4C);
        stick(7'h05);
        wint(1'b1, 40);
        wint(1'b0, 60);
        // The pulse has already been seen for three cycles when its fall is timed.
        chk(n + 3, 32'h14);
        apb(1'b0, 20'hFFFF0, 8'h00);
        stick(7'h05);
        wint(1'b1, 40);
        apb(1'b0, 20'hFFFF0, 8'h00);
        wint(1'b0, 4);
        // Hour and minute fields take part in the match when their match bit is zero.
        apb(1'b1, 20'hFFFF0, 8'h02);
        apb(1'b1, 20'hFFFF4, 8'h01);
        apb(1'b0, 20'hFFFF4, 8'h00);
        chk(rd, 32'h01);
        apb(1'b1, 20'hFFFF0, 8'h00);
        stick(7'h05);
        apb(1'b0, 20'hFFFF0, 8'h00);
        chk(rd, 32'h00);
        apb(1'b1, 20'hFFFF0, 8'h02);
        apb(1'b1, 20'hFFFF4, 8'h00);
        apb(1'b1, 20'hFFFF3, 8'h01);
        apb(1'b1, 20'hFFFF0, 8'h00);
        cmin <= 7'h01;
        stick(7'h05);
        apb(1'b0, 20'hFFFF0, 8'h00);
        chk(rd, 32'h40);
        apb(1'b1, 20'hFFFF6, 8'h28);
        vcc <= 1'b0;
        pfd <= 1'b1;
        repeat (10) @(posedge pclk);
        chk(int_o, 1'b0);
        apb(1'b0, 20'hFFFF0, 8'h00);
        chk({rd[31:1], er}, 32'h1);
        vcc <= 1'b1;
        repeat (5) @(posedge pclk);
        apb(1'b0, 20'hFFFF0, 8'h00);
        chk(rd, 32'h20);
        end_of_test();
    end
endmodule : tb_top
